// [pfc_regs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef PFC_REGS_SVH
`define PFC_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PFC_OFS_CTRL 6'h00
`define PFC_OFS_SEL 6'h01
`define PFC_OFS_PRESC 6'h02
`define PFC_OFS_INV 6'h03
`define PFC_OFS_STATUS 6'h04
`define PFC_OFS_FREQ0 6'h08
`define PFC_OFS_FREQ4 6'h0C
`define PFC_OFS_NOM0 6'h10
`define PFC_OFS_NOM4 6'h14
`define PFC_OFS_SSTEP0 6'h18
`define PFC_OFS_SRATE0 6'h1A
`define PFC_OFS_FBINT0 6'h20
`define PFC_OFS_FBREM0 6'h28
`define PFC_OFS_FBDEN0 6'h2C
`define PFC_OFS_FBBP 6'h30
`define PFC_OFS_VDIV1 6'h31
`define PFC_OFS_VDIV2 6'h32
`define PFC_OFS_LAST 6'h32
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PFC_CTRL_EN 0
`define PFC_CTRL_MODE_LO 1
`define PFC_CTRL_PSW 3
`define PFC_CTRL_PSEL_LO 4
`define PFC_CTRL_XTAL 6
`define PFC_SEL_ALT_LO 4
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PFC_RST_BYTE 8'h00
`define PFC_RST_BP 8'h09
`define PFC_RST_VDIV 8'h06
`define PFC_RST_SRATE 16'h0640
// ----------------------------------------
// Timing
// ----------------------------------------
`define PFC_CLK_HZ 100000000
`define PFC_SS_RATE_MIN_HZ 25000
`define PFC_SS_RATE_MAX_HZ 55000
`define PFC_SS_HALF_MIN ((`PFC_CLK_HZ + 2 * `PFC_SS_RATE_MAX_HZ - 1) / (2 * `PFC_SS_RATE_MAX_HZ))
`define PFC_SS_HALF_MAX (`PFC_CLK_HZ / (2 * `PFC_SS_RATE_MIN_HZ))
`define PFC_LOCK_QUAL_NS 1000
`define PFC_LOCK_QUAL_CYC (`PFC_LOCK_QUAL_NS / 10)
`endif

// [pfc_pkg.sv]
// Types shared by the frequency-control block
package pfc_pkg;
  typedef enum logic [2:0] {
    PFC_SS_IDLE = 3'b001,
    PFC_SS_RISE = 3'b010,
    PFC_SS_FALL = 3'b100
  } pfc_ss_state_type;

  typedef struct packed {
    logic run;
    logic [1:0] mode;
    logic pin_switch_enable;
    logic [1:0] switch_pin_select;
    logic xtal_pick;
  } pfc_ctrl_type;

  typedef struct packed {
    logic [2:0] loop_input_select;
    logic [2:0] loop_alternate_select;
  } pfc_mux_type;

  typedef struct packed {
    logic [8:0] integer_part;
    logic [32:0] fraction;
    logic [31:0] remainder;
    logic [31:0] denominator;
  } pfc_feedback_type;
endpackage

// [pfc_divider.sv]
// Edge-counting clock divider with optional inversion
`timescale 1ns/1ns
`default_nettype none
module pfc_divider
  import pfc_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic clk_in,
  input wire logic [W-1:0] divisor,
  input wire logic invert,
  output logic clk_out
);
  logic in_q;
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic rise;
  logic bypass;
  logic div_lvl;
  logic [W:0] half;

  // ----------------------------------------
  // Edge count and level decode
  // ----------------------------------------
  assign rise = clk_in & ~in_q;
  assign bypass = (divisor <= W'(1));
  assign cnt_d = (cnt_q >= divisor - W'(1)) ? '0 : cnt_q + W'(1);
  assign half = ({1'b0, divisor} + (W+1)'(1)) >> 1;
  assign div_lvl = bypass ? clk_in : ({1'b0, cnt_q} < half);

  // Count input rising edges
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      in_q <= 1'b0;
      cnt_q <= '0;
      clk_out <= 1'b0;
    end else if (ce) begin
      in_q <= clk_in;
      if (rise && !bypass) begin
        cnt_q <= cnt_d;
      end
      clk_out <= div_lvl ^ invert;
    end
  end
endmodule
`default_nettype wire

// [pfc_top.sv]
// Frequency control: oscillator word, spread spectrum, loop input and feedback
// Operation
// RULE1: oscillator mode drives output from a 40-bit software word, digital loop off.
// RULE2: readable 40-bit nominal word gives zero offset against master clock.
// RULE3: software computes each word from the nominal, never the previous word.
// RULE4: software keeps words within 1000ppm of nominal, 500ppm of previous.
// RULE5: with spread spectrum, total deviation stays within 5000ppm of nominal.
// RULE6: spread mode makes triangle center spread, rate 25kHz to 55kHz.
// RULE7: select 0xx locks loop to inputs one to three, reference or crystal.
// RULE8: pin switching off means primary select field alone steers the multiplexer.
// RULE9: pin switching on picks primary when pin low, alternate when high.
// RULE10: switch pin field chooses which general-purpose pin steers the multiplexer.
// RULE11: each input has prescaler 1, 2, 4 or 8; reference pin has none.
// RULE12: software divides all enabled inputs to one detector frequency.
// RULE13: each input has an invert control on the path to the loop.
// RULE14: select 11x locks loop to digital loop output, fractional multiplication.
// RULE15: divider equals integer term plus remainder over denominator scaled.
// RULE16: integer term has 9 or 7 integer bits, up to 33 fraction bits.
// RULE17: software normally sets binary point 9, never below 12 fraction bits.
// RULE18: software derives remainder and denominator from the truncated ratio.
// RULE19: two high-speed dividers each divide the oscillator clock down.
// RULE20: loop runs only while enabled; rising enable restarts lock acquisition.
// RULE21: two status bits report loop lock in real time; loop_lock_flag_second sets only after LOCK_QUAL cycles of steady lock.
// RULE22: new frequency word applies whole, only after its last byte.
`timescale 1ns/1ns
`default_nettype none
`include "pfc_regs.svh"
module pfc_top
  import pfc_pkg::*;
#(
  parameter logic [39:0] NOMINAL_WORD = 40'h0080000000,
  parameter int LOCK_QUAL = `PFC_LOCK_QUAL_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] in_clk,
  input wire logic master_reference_pin,
  input wire logic xtal_doubled,
  input wire logic [3:0] gpio,
  input wire logic vco_clk,
  input wire logic loop_lock_detect,
  output logic loop_ref_clk,
  output logic combined_mode,
  output logic digital_loop_shutdown,
  output logic [39:0] oscillator_frequency_word,
  output logic nco_clk,
  output logic analog_loop_enable,
  output logic loop_restart,
  output logic [8:0] fb_integer,
  output logic [32:0] fb_fraction,
  output logic [31:0] feedback_remainder,
  output logic [31:0] feedback_denominator,
  output logic vco_div_one_clk,
  output logic vco_div_two_clk,
  output logic loop_lock_flag,
  output logic loop_lock_flag_second
);
  localparam logic [1:0] MODE_NCO = 2'b01;
  localparam logic [1:0] MODE_SSM = 2'b10;
  localparam logic [15:0] HALF_MIN = 16'(`PFC_SS_HALF_MIN);
  localparam logic [15:0] HALF_MAX = 16'(`PFC_SS_HALF_MAX);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] cfg_q [0:50];
  logic [39:0] freq_live_q;
  logic wr_ok;
  logic [7:0] rd_d;
  pfc_ctrl_type ctrl;
  pfc_mux_type mux;
  pfc_feedback_type fb_d;

  // Writable range excludes status and nominal word
  assign wr_ok = reg_wr && (reg_addr <= `PFC_OFS_LAST) && (reg_addr != `PFC_OFS_STATUS)
    && !((reg_addr >= `PFC_OFS_NOM0) && (reg_addr <= `PFC_OFS_NOM4));

  // Byte storage; frequency word commits on its top byte
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      for (int i = 0; i <= 50; i++) begin
        cfg_q[i] <= `PFC_RST_BYTE;
      end
      cfg_q[`PFC_OFS_FBBP] <= `PFC_RST_BP;
      cfg_q[`PFC_OFS_VDIV1] <= `PFC_RST_VDIV;
      cfg_q[`PFC_OFS_VDIV2] <= `PFC_RST_VDIV;
      cfg_q[`PFC_OFS_SRATE0] <= 8'(`PFC_RST_SRATE);
      cfg_q[`PFC_OFS_SRATE0 + 6'h01] <= 8'(`PFC_RST_SRATE >> 8);
      freq_live_q <= NOMINAL_WORD;
    end else if (ce) begin
      if (wr_ok) begin
        cfg_q[reg_addr] <= reg_wdata;
      end
      if (wr_ok && reg_addr == `PFC_OFS_FREQ4) begin
        freq_live_q <= {reg_wdata, cfg_q[`PFC_OFS_FREQ0 + 6'h03], cfg_q[`PFC_OFS_FREQ0 + 6'h02],
          cfg_q[`PFC_OFS_FREQ0 + 6'h01], cfg_q[`PFC_OFS_FREQ0]}; // see RULE22
      end
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  assign ctrl = '{run: cfg_q[`PFC_OFS_CTRL][`PFC_CTRL_EN],
    mode: cfg_q[`PFC_OFS_CTRL][`PFC_CTRL_MODE_LO +: 2],
    pin_switch_enable: cfg_q[`PFC_OFS_CTRL][`PFC_CTRL_PSW],
    switch_pin_select: cfg_q[`PFC_OFS_CTRL][`PFC_CTRL_PSEL_LO +: 2],
    xtal_pick: cfg_q[`PFC_OFS_CTRL][`PFC_CTRL_XTAL]};
  assign mux = '{loop_input_select: cfg_q[`PFC_OFS_SEL][2:0],
    loop_alternate_select: cfg_q[`PFC_OFS_SEL][`PFC_SEL_ALT_LO +: 3]};

  // ----------------------------------------
  // Oscillator word and spread spectrum
  // ----------------------------------------
  pfc_ss_state_type ss_q;
  pfc_ss_state_type ss_d;
  logic [15:0] ss_cnt_q;
  logic [15:0] ss_half;
  logic [15:0] ss_raw;
  logic [15:0] ss_step;
  logic signed [40:0] dev_q;
  logic signed [40:0] dev_d;
  logic ss_turn;
  logic ssm_on;
  logic [39:0] word_d;
  logic [39:0] acc_q;

  assign ssm_on = (ctrl.mode == MODE_SSM);
  assign ss_raw = {cfg_q[`PFC_OFS_SRATE0 + 6'h01], cfg_q[`PFC_OFS_SRATE0]};
  assign ss_step = {cfg_q[`PFC_OFS_SSTEP0 + 6'h01], cfg_q[`PFC_OFS_SSTEP0]};
  // Half period clamped to the legal modulation rates
  assign ss_half = (ss_raw < HALF_MIN) ? HALF_MIN :
    (ss_raw > HALF_MAX) ? HALF_MAX : ss_raw; // see RULE6
  assign ss_turn = (ss_cnt_q >= ss_half - 16'h0001);
  assign dev_d = (ss_q == PFC_SS_RISE) ? dev_q + 41'(ss_step) :
    (ss_q == PFC_SS_FALL) ? dev_q - 41'(ss_step) : 41'sh0;
  assign word_d = freq_live_q + dev_q[39:0]; // see RULE1

  // Triangle direction sequencer
  always_comb begin
    ss_d = ss_q;
    case (ss_q)
      PFC_SS_IDLE: begin
        if (ssm_on) begin
          ss_d = PFC_SS_RISE;
        end
      end
      PFC_SS_RISE: begin
        if (!ssm_on) begin
          ss_d = PFC_SS_IDLE;
        end else if (ss_turn) begin
          ss_d = PFC_SS_FALL;
        end
      end
      PFC_SS_FALL: begin
        if (!ssm_on) begin
          ss_d = PFC_SS_IDLE;
        end else if (ss_turn) begin
          ss_d = PFC_SS_RISE;
        end
      end
      default: begin
        ss_d = PFC_SS_IDLE;
      end
    endcase
  end

  // Center spread: first leg is a quarter period long
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ss_q <= PFC_SS_IDLE;
      ss_cnt_q <= 16'h0000;
      dev_q <= 41'sh0;
    end else if (ce) begin
      ss_q <= ss_d;
      dev_q <= dev_d; // see RULE6
      if (ss_q == PFC_SS_IDLE) begin
        ss_cnt_q <= ss_half >> 1;
      end else if (ss_turn) begin
        ss_cnt_q <= 16'h0000;
      end else begin
        ss_cnt_q <= ss_cnt_q + 16'h0001;
      end
    end
  end

  // Phase accumulator forms the oscillator clock
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      acc_q <= 40'h0000000000;
      nco_clk <= 1'b0;
      oscillator_frequency_word <= NOMINAL_WORD;
      digital_loop_shutdown <= 1'b0;
    end else if (ce) begin
      acc_q <= acc_q + oscillator_frequency_word;
      nco_clk <= acc_q[39];
      oscillator_frequency_word <= (ctrl.mode == MODE_NCO || ssm_on) ? word_d : NOMINAL_WORD;
      digital_loop_shutdown <= (ctrl.mode == MODE_NCO) || ssm_on; // see RULE1
    end
  end

  // ----------------------------------------
  // Input prescalers and loop multiplexer
  // ----------------------------------------
  logic [2:0] presc_clk;
  logic [2:0] sel_eff;
  logic ref_mux_d;

  // One divider per input, with invert
  for (genvar g = 0; g < 3; g++) begin : g_presc
    pfc_divider #(.W(4)) u_presc (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .ce(ce),
      .clk_in(in_clk[g]),
      .divisor(4'h1 << cfg_q[`PFC_OFS_PRESC][2*g +: 2]), // see RULE11
      .invert(cfg_q[`PFC_OFS_INV][g]), // see RULE13
      .clk_out(presc_clk[g])
    );
  end

  // Primary or pin-chosen alternate select
  assign sel_eff = (ctrl.pin_switch_enable && gpio[ctrl.switch_pin_select]) ? // see RULE9 RULE10
    mux.loop_alternate_select : mux.loop_input_select; // see RULE8
  assign ref_mux_d = (sel_eff == 3'h0) ? presc_clk[0] :
    (sel_eff == 3'h1) ? presc_clk[1] :
    (sel_eff == 3'h2) ? presc_clk[2] :
    (sel_eff == 3'h3) ? (ctrl.xtal_pick ? xtal_doubled : master_reference_pin) : // see RULE7
    (sel_eff[2:1] == 2'b11) ? nco_clk : 1'b0; // see RULE14

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      loop_ref_clk <= 1'b0;
      combined_mode <= 1'b0;
    end else if (ce) begin
      loop_ref_clk <= ref_mux_d;
      combined_mode <= (sel_eff[2:1] == 2'b11); // see RULE14
    end
  end

  // ----------------------------------------
  // Feedback divider alignment
  // ----------------------------------------
  logic [41:0] fb_int_raw;
  logic [5:0] fb_bp;
  logic [41:0] fb_aligned;

  assign fb_int_raw = {cfg_q[`PFC_OFS_FBINT0 + 6'h05][1:0], cfg_q[`PFC_OFS_FBINT0 + 6'h04],
    cfg_q[`PFC_OFS_FBINT0 + 6'h03], cfg_q[`PFC_OFS_FBINT0 + 6'h02],
    cfg_q[`PFC_OFS_FBINT0 + 6'h01], cfg_q[`PFC_OFS_FBINT0]};
  assign fb_bp = (cfg_q[`PFC_OFS_FBBP][5:0] > 6'd33) ? 6'd33 : cfg_q[`PFC_OFS_FBBP][5:0];
  // Integer term shifted to a fixed 33-bit fraction
  assign fb_aligned = fb_int_raw << fb_bp; // see RULE15
  assign fb_d = '{integer_part: fb_aligned[41:33] & (combined_mode ? 9'h07F : 9'h1FF), // see RULE16
    fraction: fb_aligned[32:0],
    remainder: {cfg_q[`PFC_OFS_FBREM0 + 6'h03], cfg_q[`PFC_OFS_FBREM0 + 6'h02],
      cfg_q[`PFC_OFS_FBREM0 + 6'h01], cfg_q[`PFC_OFS_FBREM0]},
    denominator: {cfg_q[`PFC_OFS_FBDEN0 + 6'h03], cfg_q[`PFC_OFS_FBDEN0 + 6'h02],
      cfg_q[`PFC_OFS_FBDEN0 + 6'h01], cfg_q[`PFC_OFS_FBDEN0]}};

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      {fb_integer, fb_fraction, feedback_remainder, feedback_denominator} <= '0;
    end else if (ce) begin
      {fb_integer, fb_fraction, feedback_remainder, feedback_denominator} <= fb_d; // see RULE15
    end
  end

  // ----------------------------------------
  // High-speed dividers of the oscillator
  // ----------------------------------------
  pfc_divider #(.W(8)) u_vdiv1 (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .clk_in(vco_clk),
    .divisor(cfg_q[`PFC_OFS_VDIV1]), // see RULE19
    .invert(1'b0),
    .clk_out(vco_div_one_clk)
  );
  pfc_divider #(.W(8)) u_vdiv2 (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .clk_in(vco_clk),
    .divisor(cfg_q[`PFC_OFS_VDIV2]), // see RULE19
    .invert(1'b0),
    .clk_out(vco_div_two_clk)
  );

  // ----------------------------------------
  // Enable sequencing and lock status
  // ----------------------------------------
  logic [15:0] qual_q;
  logic lock_now;

  assign lock_now = analog_loop_enable && !loop_restart && loop_lock_detect;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      analog_loop_enable <= 1'b0;
      loop_restart <= 1'b0;
      loop_lock_flag <= 1'b0;
      loop_lock_flag_second <= 1'b0;
      qual_q <= 16'h0000;
    end else if (ce) begin
      analog_loop_enable <= ctrl.run; // see RULE20
      loop_restart <= ctrl.run && !analog_loop_enable; // see RULE20
      loop_lock_flag <= lock_now; // see RULE21
      qual_q <= !lock_now ? 16'h0000 : (qual_q == 16'(LOCK_QUAL)) ? qual_q : qual_q + 16'h0001;
      loop_lock_flag_second <= lock_now && (qual_q == 16'(LOCK_QUAL)); // see RULE21
    end
  end

  // ----------------------------------------
  // Read port, data one cycle after strobe
  // ----------------------------------------
  assign rd_d = (reg_addr == `PFC_OFS_STATUS) ?
      {1'b0, sel_eff, analog_loop_enable, combined_mode, loop_lock_flag_second, loop_lock_flag} :
    (reg_addr >= `PFC_OFS_FREQ0 && reg_addr <= `PFC_OFS_FREQ4) ?
      freq_live_q[8*(reg_addr - `PFC_OFS_FREQ0) +: 8] :
    (reg_addr >= `PFC_OFS_NOM0 && reg_addr <= `PFC_OFS_NOM4) ?
      NOMINAL_WORD[8*(reg_addr - `PFC_OFS_NOM0) +: 8] : // see RULE2
    (reg_addr <= `PFC_OFS_LAST) ? cfg_q[reg_addr] : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_d : 8'h00;
    end
  end
endmodule
`default_nettype wire

// [pfc_checker.sv]
// Port-level checks for the frequency-control block
`timescale 1ns/1ns
`default_nettype none
`include "pfc_regs.svh"
module pfc_checker
  import pfc_pkg::*;
#(
  parameter logic [39:0] NOMINAL_WORD = 40'h0080000000
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] gpio,
  input wire logic loop_lock_detect,
  input wire logic loop_ref_clk,
  input wire logic combined_mode,
  input wire logic digital_loop_shutdown,
  input wire logic [39:0] oscillator_frequency_word,
  input wire logic analog_loop_enable,
  input wire logic loop_restart,
  input wire logic loop_lock_flag,
  input wire logic loop_lock_flag_second
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // Shadow of the control fields
  // ----------------------------------------
  logic [6:0] ctl_q;
  logic [5:0] sel_q;
  logic [1:0] mode1_q, mode2_q;
  logic comb_q;
  wire wr_ctl = ce && reg_wr && reg_addr == `PFC_OFS_CTRL;
  wire wr_sel = ce && reg_wr && reg_addr == `PFC_OFS_SEL;
  wire pin_hi = ctl_q[3] && gpio[ctl_q[5:4]];
  wire [2:0] eff_sel = pin_hi ? sel_q[5:3] : sel_q[2:0];
  wire settled = ctl_q[2:1] == mode1_q && mode1_q == mode2_q;
  wire nco = settled && ctl_q[2:1] == 2'b01;
  wire low_byte = reg_addr >= `PFC_OFS_FREQ0 && reg_addr < `PFC_OFS_FREQ4;
  // Capture writes, delay mode to let outputs settle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctl_q <= '0;
      sel_q <= '0;
      mode1_q <= '0;
      mode2_q <= '0;
      comb_q <= 1'b0;
    end else begin
      ctl_q <= wr_ctl ? reg_wdata[6:0] : ctl_q;
      sel_q <= wr_sel ? {reg_wdata[6:4], reg_wdata[2:0]} : sel_q;
      mode1_q <= ctl_q[2:1];
      mode2_q <= mode1_q;
      comb_q <= eff_sel[2:1] == 2'b11;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_msb_write;
    nco && ce && reg_wr && reg_addr == `PFC_OFS_FREQ4;
  endsequence
  sequence s_restart_pulse;
    loop_restart ##1 !loop_restart;
  endsequence
  property p_word_commit;
    s_msb_write |=> ##1 oscillator_frequency_word[39:32] == $past(reg_wdata, 2);
  endproperty
  a_word_commit: assert property (p_word_commit)
    else $error("word msb not applied");
  property p_partial_hold;
    nco && ce && reg_wr && low_byte |=> ##1 $stable(oscillator_frequency_word);
  endproperty
  a_partial_hold: assert property (p_partial_hold)
    else $error("partial word reached output");
  property p_nominal;
    settled && ctl_q[2:1] == 2'b00 |-> oscillator_frequency_word == NOMINAL_WORD;
  endproperty
  a_nominal: assert property (p_nominal)
    else $error("idle word not nominal");
  property p_shutdown;
    settled |-> digital_loop_shutdown == (ctl_q[2:1] == 2'b01 || ctl_q[2:1] == 2'b10);
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown flag wrong");
  property p_combined;
    combined_mode == comb_q;
  endproperty
  a_combined: assert property (p_combined)
    else $error("combined mode wrong");
  property p_ref_gated;
    (eff_sel[2:1] == 2'b10) [*2] |-> !loop_ref_clk;
  endproperty
  a_ref_gated: assert property (p_ref_gated)
    else $error("unused select drives loop");
  property p_enable;
    wr_ctl |-> ##[1:2] analog_loop_enable == ctl_q[0];
  endproperty
  a_enable: assert property (p_enable)
    else $error("enable not followed");
  property p_restart;
    $rose(analog_loop_enable) |-> ##[0:1] s_restart_pulse;
  endproperty
  a_restart: assert property (p_restart)
    else $error("no single restart pulse");
  property p_requalify;
    loop_restart |=> !loop_lock_flag_second [*2];
  endproperty
  a_requalify: assert property (p_requalify)
    else $error("lock kept over restart");
  property p_lock_drop;
    !loop_lock_detect |=> !loop_lock_flag && !loop_lock_flag_second;
  endproperty
  a_lock_drop: assert property (p_lock_drop)
    else $error("lock flag not real time");
  property p_lock_pair;
    loop_lock_flag_second |-> loop_lock_flag;
  endproperty
  a_lock_pair: assert property (p_lock_pair)
    else $error("second flag without lock");
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside slot");
endmodule
bind pfc_top pfc_checker #(.NOMINAL_WORD(NOMINAL_WORD)) u_pfc_checker (.*);
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the frequency-control block
`timescale 1ns/1ns
`default_nettype none
`include "pfc_regs.svh"
module tb_top
  import pfc_pkg::*;
;
  localparam logic [39:0] NOM = 40'h0080000000;
  localparam int QUAL = 4;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [5:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] in_clk = '0;
  logic master_reference_pin = 1'b0;
  logic xtal_doubled = 1'b0;
  logic [3:0] gpio = '0;
  logic vco_clk = 1'b0;
  logic loop_lock_detect = 1'b0;
  logic run = 1'b0, rd_d = 1'b0;
  logic [7:0] reg_rdata;
  logic loop_ref_clk, combined_mode, digital_loop_shutdown, nco_clk;
  logic analog_loop_enable, loop_restart, vco_div_one_clk, vco_div_two_clk;
  logic loop_lock_flag, loop_lock_flag_second;
  logic [39:0] oscillator_frequency_word;
  logic [8:0] fb_integer;
  logic [32:0] fb_fraction;
  logic [31:0] feedback_remainder, feedback_denominator;
  logic [7:0] exp_q[$];
  int miscompares = 0, n_checks = 0;
  pfc_top #(.NOMINAL_WORD(NOM), .LOCK_QUAL(QUAL)) dut (.*);
  always #5 ref_clk = ~ref_clk;
  // Input clocks toggle while run is set, read slot tracking
  always @(posedge ref_clk) begin
    in_clk <= run ? ~in_clk : 3'b111;
    master_reference_pin <= run ? ~master_reference_pin : 1'b1;
    xtal_doubled <= (run && !in_clk[0]) ? ~xtal_doubled : xtal_doubled;
    vco_clk <= ~vco_clk;
    rd_d <= reg_rd;
  end
  // Read data checked against the oldest noted value
  always @(negedge ref_clk) if (rd_d) chk(reg_rdata, exp_q.pop_front());
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  // Counts rises of s, and cycles where s equals input one
  task automatic count(ref logic s, input int c, output int r, output int m);
    logic p;
    repeat (4) @(negedge ref_clk);
    p = s;
    {r, m} = 64'd0;
    repeat (c) begin
      @(negedge ref_clk);
      r += int'(s && !p);
      m += int'(s == in_clk[0]);
      p = s;
    end
  endtask
  task automatic near(input int n, input int e);
    chk(64'(n >= e - 1 && n <= e + 1), 64'd1);
  endtask
  task automatic end_sim;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    end_sim();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [39:0] w, prev, hi, lo, cur;
    logic [47:0] t;
    logic [31:0] r, d;
    int n, m, h, dv, dir, nd, mm[2];
    void'($urandom(32'h413A7F24));
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    // Reset values, read-only and unmapped places
    rd(`PFC_OFS_CTRL, 8'h00);
    rd(`PFC_OFS_FBBP, `PFC_RST_BP);
    rd(`PFC_OFS_VDIV1, `PFC_RST_VDIV);
    rd(`PFC_OFS_SRATE0, 8'(`PFC_RST_SRATE));
    wr(`PFC_OFS_NOM0, 8'hA5);
    wr(6'h3F, 8'hFF);
    rd(6'h3F, 8'h00);
    ce <= 1'b0;
    wr(`PFC_OFS_CTRL, 8'h02);
    ce <= 1'b1;
    rd(`PFC_OFS_CTRL, 8'h00);
    for (int i = 0; i < 5; i++) rd(`PFC_OFS_NOM0 + 6'(i), NOM[8*i +: 8]);
    chk(oscillator_frequency_word, NOM);
    // Oscillator words derived afresh from nominal, within 500ppm
    wr(`PFC_OFS_CTRL, 8'h02);
    for (int k = 0; k < 3; k++) begin
      w = NOM + 40'($urandom_range(1000000)) - 40'd500000;
      prev = oscillator_frequency_word;
      for (int i = 0; i < 4; i++) wr(`PFC_OFS_FREQ0 + 6'(i), w[8*i +: 8]);
      chk(oscillator_frequency_word, prev);
      wr(`PFC_OFS_FREQ4, w[39:32]);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(oscillator_frequency_word, w);
      for (int i = 0; i < 5; i++) rd(`PFC_OFS_FREQ0 + 6'(i), w[8*i +: 8]);
    end
    wr(`PFC_OFS_CTRL, 8'h00);
    repeat (3) @(negedge ref_clk);
    chk(oscillator_frequency_word, NOM);
    // Spread at both clamped rates, small step keeps within 5000ppm
    wr(`PFC_OFS_SSTEP0, 8'h10);
    for (int j = 0; j < 2; j++) begin
      h = j ? `PFC_SS_HALF_MAX : `PFC_SS_HALF_MIN;
      wr(`PFC_OFS_SRATE0 + 6'd1, j ? 8'hFF : 8'h01);
      wr(`PFC_OFS_CTRL, 8'h04);
      repeat (2) @(negedge ref_clk);
      {hi, lo, cur} = {3{oscillator_frequency_word}};
      {dir, nd} = 64'd0;
      repeat (8 * h) begin
        @(negedge ref_clk);
        dv = (oscillator_frequency_word > cur) ? 1 : (oscillator_frequency_word < cur) ? -1 : 0;
        nd += int'(dv != 0 && dir != 0 && dv != dir);
        dir = (dv != 0) ? dv : dir;
        cur = oscillator_frequency_word;
        hi = (cur > hi) ? cur : hi;
        lo = (cur < lo) ? cur : lo;
      end
      dv = int'(hi - w) - int'(w - lo);
      chk(64'(hi > w && dv >= -32 && dv <= 32), 64'd1);
      near(nd, 8);
      wr(`PFC_OFS_CTRL, 8'h00);
    end
    // Every primary select, pin switching off
    for (int s = 0; s < 8; s++) begin
      wr(`PFC_OFS_SEL, 8'(s));
      repeat (3) @(negedge ref_clk);
      chk(combined_mode, s >= 6);
      rd(`PFC_OFS_STATUS, 8'((s << 4) | (s >= 6 ? 4 : 0)));
    end
    // Pin switching on each general-purpose pin
    wr(`PFC_OFS_SEL, 8'h60);
    for (int p = 0; p < 4; p++) begin
      wr(`PFC_OFS_CTRL, 8'h08 | 8'(p << 4));
      for (int g = 0; g < 2; g++) begin
        @(posedge ref_clk);
        gpio <= g ? 4'(1 << p) : ~4'(1 << p);
        repeat (3) @(negedge ref_clk);
        chk(combined_mode, g);
      end
    end
    // Prescaler ratios, then the undivided reference pin
    wr(`PFC_OFS_CTRL, 8'h00);
    wr(`PFC_OFS_SEL, 8'h00);
    @(posedge ref_clk);
    run <= 1'b1;
    for (int f = 0; f < 4; f++) begin
      wr(`PFC_OFS_PRESC, 8'(f));
      count(loop_ref_clk, 64, n, m);
      near(n, 32 >> f);
    end
    wr(`PFC_OFS_SEL, 8'h03);
    count(loop_ref_clk, 64, n, m);
    near(n, 32);
    wr(`PFC_OFS_CTRL, 8'h40);
    count(loop_ref_clk, 64, n, m);
    near(n, 16);
    wr(`PFC_OFS_SEL, 8'h00);
    wr(`PFC_OFS_PRESC, 8'h00);
    for (int v = 0; v < 2; v++) begin
      wr(`PFC_OFS_INV, 8'(v));
      count(loop_ref_clk, 32, n, mm[v]);
    end
    chk(64'(mm[0] + mm[1] == 32 && (mm[0] == 0 || mm[0] == 32)), 64'd1);
    count(vco_div_one_clk, 120, n, m);
    near(n, 120 / (2 * `PFC_RST_VDIV));
    wr(`PFC_OFS_VDIV2, 8'h03);
    count(vco_div_two_clk, 120, n, m);
    near(n, 20);
    // Feedback terms, enable, lock and relock
    t = {6'h00, 42'({$urandom, $urandom})};
    d = $urandom;
    r = $urandom_range(d - 32'h1);
    for (int i = 0; i < 6; i++) wr(`PFC_OFS_FBINT0 + 6'(i), t[8*i +: 8]);
    for (int i = 0; i < 4; i++) wr(`PFC_OFS_FBREM0 + 6'(i), r[8*i +: 8]);
    for (int i = 0; i < 4; i++) wr(`PFC_OFS_FBDEN0 + 6'(i), d[8*i +: 8]);
    wr(`PFC_OFS_CTRL, 8'h01);
    loop_lock_detect <= 1'b1;
    repeat (QUAL + 4) @(negedge ref_clk);
    chk(fb_integer, t[32:24]);
    chk(fb_fraction, {t[23:0], 9'h000});
    chk(feedback_remainder, r);
    chk(feedback_denominator, d);
    rd(`PFC_OFS_STATUS, 8'h0B);
    wr(`PFC_OFS_SEL, 8'h06);
    repeat (3) @(negedge ref_clk);
    chk(fb_integer, {2'b00, t[30:24]});
    wr(`PFC_OFS_CTRL, 8'h00);
    wr(`PFC_OFS_CTRL, 8'h01);
    repeat (QUAL + 4) @(negedge ref_clk);
    chk(loop_lock_flag_second, 1'b1);
    @(posedge ref_clk);
    loop_lock_detect <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({loop_lock_flag, loop_lock_flag_second}, 2'b00);
    repeat (4) @(posedge ref_clk);
    end_sim();
  end
endmodule
`default_nettype wire
